// ==== pdmo_pkg.sv ====
// Purpose : Shared constants and types for the PDM shared-line output block
// Assumes : System clock mclk at 100 MHz; link clock sampled as a plain input
// Notes   : Timing counts derive from times in their own units
package pdmo_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned MCLK_HZ        = 100_000_000;
  localparam int unsigned SLEEP_FREQ_HZ  = 1_000;      // Below this the block sleeps
  // Longest link clock period tolerated before sleep, in system cycles (round down)
  localparam int unsigned SLEEP_CYCLES   = MCLK_HZ / SLEEP_FREQ_HZ;
  localparam int unsigned WAKE_LINK_CYC  = 32_768;     // Link cycles before first drive
  localparam int unsigned IDLE_CNT_W     = 17;
  localparam int unsigned WAKE_CNT_W     = 16;
  localparam logic [IDLE_CNT_W-1:0] IDLE_ZERO = 17'h00000;
  localparam logic [WAKE_CNT_W-1:0] WAKE_ZERO = 16'h0000;

  // ----------------------------------------------------------------------
  // Buffer shape
  // ----------------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_WIDTH = 1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {PDMO_SLEEP, PDMO_WAKE, PDMO_RUN} pdmo_state_e;

  // Data pin as two signals
  typedef struct packed {
    logic dout;   // Level driven
    logic oe_n;   // Low while driving
  } pdmo_pin_s;

endpackage

// ==== pdmo_fifo.sv ====
// Purpose : Small valid/ready FIFO for the modulator bit stream
// Assumes : One clock, synchronous use only
// Notes   : Depth must be a power of two
`timescale 1ns/1ns
module pdmo_fifo
  import pdmo_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             mclk,      // System clock
  input  wire logic             rstn,      // Async reset, active low
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Space available
  input  wire logic [WIDTH-1:0] in_data,   // Write word
  output logic                  out_valid, // Word available
  input  wire logic             out_ready, // Read accept
  output logic [WIDTH-1:0]      out_data   // Head word
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  // ----------------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------------
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // Storage has no reset; only pointers and count need a defined value
  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// ==== pdmo_top.sv ====
// Purpose : Drives a 1-bit PDM stream onto a shared, half-period data line
// Assumes : Link clock comes from the host; modulator bits arrive on mclk
// Notes   : Link clock is sampled by mclk, so edges are seen ~20-30 ns late
`timescale 1ns/1ns

// Functional notes
// - One modulator bit per link period out
// - Left on falling, right on rising edge
// - Release line for the other half
// - Select low right slot, high left
// - Drive only on own channel edge
// - Link clock under 1 kHz: sleep, hi-Z
// - Drive only after 32768 link cycles
// - Ones density encodes signal amplitude
module pdmo_top
  import pdmo_pkg::*;
(
  input  wire logic mclk,       // System clock, 100 MHz
  input  wire logic rstn,       // Async reset, active low
  input  wire logic link_clk,   // Clock pin from host
  input  wire logic lr_select,  // Channel select pin, high = left
  input  wire logic mod_valid,  // Modulator bit valid
  output logic      mod_ready,  // Buffer can accept a bit
  input  wire logic mod_bit,    // Modulator PDM bit
  output logic      data_out,   // Data pin level
  output logic      data_oe_n,  // Data pin enable, low drives
  output logic      asleep      // Sleep state flag
);

  localparam int unsigned FILL_W = $clog2(FIFO_DEPTH) + 1;  // Fill level holds 0 to depth

  pdmo_state_e state;
  pdmo_state_e next_state;
  logic [2:0]            clk_sync;   // [0] first stage, read only by [1]
  logic [1:0]            sel_sync;
  logic                  left_sel;
  logic                  rise;
  logic                  fall;
  logic                  own_edge;
  logic                  other_edge;
  logic [IDLE_CNT_W-1:0] idle_cnt;
  logic [WAKE_CNT_W-1:0] wake_cnt;
  logic                  idle_hit;
  logic                  fifo_in_ready;
  logic                  fifo_valid;
  logic                  fifo_pop;
  logic                  fifo_wr;
  logic [FILL_W-1:0]     fill;       // Shadow of the buffer fill level
  logic [FILL_W-1:0]     next_fill;
  logic [FIFO_WIDTH-1:0] fifo_data;
  pdmo_pin_s             pin;

  // ----------------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------------
  // Two flops before any logic; third flop only for edge compare
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clk_sync <= 3'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], link_clk};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sel_sync <= 2'h0;
    end else begin
      sel_sync <= {sel_sync[0], lr_select};
    end
  end

  assign left_sel = sel_sync[1];
  assign rise       = clk_sync[1] && !clk_sync[2];
  assign fall       = !clk_sync[1] && clk_sync[2];
  assign own_edge   = left_sel ? fall : rise;
  assign other_edge = left_sel ? rise : fall;

  // ----------------------------------------------------------------------
  // Clock activity monitor
  // ----------------------------------------------------------------------
  // detect stopped clock
  // A period longer than SLEEP_CYCLES of mclk means below the sleep frequency
  assign idle_hit = (idle_cnt == IDLE_CNT_W'(SLEEP_CYCLES - 1));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt <= IDLE_ZERO;
    end else if (rise || state == PDMO_SLEEP) begin
      idle_cnt <= IDLE_ZERO;
    end else if (!idle_hit) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Sleep / wake sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      PDMO_SLEEP: begin
        if (rise) begin
          next_state = PDMO_WAKE;
        end
      end
      PDMO_WAKE: begin
        if (idle_hit) begin
          next_state = PDMO_SLEEP;
        end else if (rise && wake_cnt == WAKE_CNT_W'(WAKE_LINK_CYC - 1)) begin
          next_state = PDMO_RUN;
        end
      end
      PDMO_RUN: begin
        if (idle_hit) begin
          next_state = PDMO_SLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= PDMO_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_cnt <= WAKE_ZERO;
    end else if (state != PDMO_WAKE) begin
      wake_cnt <= WAKE_ZERO;
    end else if (rise) begin
      wake_cnt <= wake_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Modulator bit buffer
  // ----------------------------------------------------------------------
  // Bits are drained one per link period once running; while not running
  // the buffer is flushed so stale bits never reach the line.
  // one bit per period
  assign fifo_pop = fifo_valid && (own_edge || state != PDMO_RUN);

  pdmo_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (mod_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (mod_bit),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Shadow fill level, tracked with the same write and pop terms as the buffer.
  // Registering ready from the live full flag would lag one cycle and let a
  // source that honours ready lose a bit each time the buffer fills.
  assign fifo_wr = mod_valid && fifo_in_ready;

  always_comb begin
    next_fill = fill;
    if (fifo_wr && !fifo_pop) begin
      next_fill = fill + 1'b1;
    end else if (fifo_pop && !fifo_wr) begin
      next_fill = fill - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fill <= '0;
    end else begin
      fill <= next_fill;
    end
  end

  // Ready comes from the fill after this edge, so it never lags the buffer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mod_ready <= 1'b0;
    end else begin
      mod_ready <= (next_fill != FILL_W'(FIFO_DEPTH));
    end
  end

  // ----------------------------------------------------------------------
  // Data pin driver
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin <= '{dout: 1'b0, oe_n: 1'b1};
    end else if (state != PDMO_RUN) begin
      pin.oe_n <= 1'b1;
    end else if (own_edge) begin
      pin.oe_n <= 1'b0;
      if (fifo_valid) begin
        pin.dout <= fifo_data[0];
      end
    end else if (other_edge) begin
      pin.oe_n <= 1'b1;
    end
  end

  assign data_out  = pin.dout;
  assign data_oe_n = pin.oe_n;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      asleep <= 1'b1;
    end else begin
      asleep <= (next_state == PDMO_SLEEP);
    end
  end

endmodule

// ==== pdmo_top_monitor.sv ====
// Purpose: Port checker for pdmo_top
// Assumes: Link halves span at least four mclk cycles
// Notes  : Wake count is a saturating tally of link rises
`timescale 1ns/1ns
module pdmo_top_monitor
  import pdmo_pkg::*;
(
  input wire logic mclk,      // System clock
  input wire logic rstn,      // Async reset
  input wire logic link_clk,  // Host clock pin
  input wire logic lr_select, // Slot select
  input wire logic mod_valid, // Bit valid
  input wire logic mod_ready, // Buffer space
  input wire logic mod_bit,   // Modulator bit
  input wire logic data_out,  // Pin level
  input wire logic data_oe_n, // Pin enable
  input wire logic asleep     // Sleep flag
);
  // ----------------------------------------
  // Helper logic and properties
  // ----------------------------------------
  logic [16:0] lk_rises;

  // Saturates well past the wake count, so no wrap hides an early drive
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lk_rises <= 17'h00000;
    end else if ($rose(link_clk) && !lk_rises[16]) begin
      lk_rises <= lk_rises + 17'h00001;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  reset_state_a: assert property ($rose(rstn) |-> asleep && data_oe_n && !mod_ready)
    else $error("outputs not at reset values");
  ready_rise_a: assert property ($rose(rstn) |-> ##1 mod_ready)
    else $error("mod_ready late after reset");
  sleep_hiz_a: assert property (asleep && $past(asleep) |-> data_oe_n)
    else $error("pin driven while asleep");
  own_edge_a: assert property ($fell(data_oe_n) |-> $past(link_clk, 2) == !lr_select)
    else $error("drive began after the wrong edge");
  drive_hold_a: assert property ($fell(data_oe_n) |-> !data_oe_n [*3])
    else $error("drive shorter than a half period");
  release_hold_a: assert property ($rose(data_oe_n) |-> data_oe_n [*3])
    else $error("release shorter than a half period");
  bit_stable_a: assert property (!data_oe_n && !$past(data_oe_n) |-> $stable(data_out))
    else $error("data changed within a drive window");
  wake_count_a: assert property ($fell(data_oe_n) |-> lk_rises >= 17'h08000)
    else $error("drive before wake count");
endmodule

bind pdmo_top pdmo_top_monitor pdmo_top_monitor_i (.mclk(mclk), .rstn(rstn), .link_clk(link_clk),
  .lr_select(lr_select), .mod_valid(mod_valid), .mod_ready(mod_ready), .mod_bit(mod_bit),
  .data_out(data_out), .data_oe_n(data_oe_n), .asleep(asleep));

// ==== pdmo_host_model.sv ====
// Purpose: Host codec model: makes the link clock, captures both slots
// Assumes: 80 ns link period, still and low while run is low
// Notes  : No keeper on the line; a released line shows the inverse
`timescale 1ns/1ns
module pdmo_host_model (
  input  wire logic run,       // Link clock enable
  input  wire logic data_out,  // Pin level
  input  wire logic data_oe_n, // Pin enable
  output logic      link_clk,  // Host clock
  output logic      left_bit,  // Last left capture
  output logic      right_bit, // Last right capture
  output logic      left_drv,  // Left slot was driven
  output logic      right_drv  // Right slot was driven
);
  logic wire_lvl = 1'b0;

  // released line keeps nothing, so show the inverse to expose reliance on it
  task automatic sample(output logic b, output logic d);
    wire_lvl = data_oe_n ? ~wire_lvl : data_out;
    b = wire_lvl;
    d = !data_oe_n;
  endtask

  // host owns the clock and captures each slot late in its half
  initial begin
    link_clk = 1'b0;
    forever begin
      if (run !== 1'b1) begin
        link_clk = 1'b0;
        @(posedge run);
        #3;
      end
      #39 sample(left_bit, left_drv);
      #1 link_clk = 1'b1;
      #39 sample(right_bit, right_drv);
      #1 link_clk = 1'b0;
    end
  end
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for pdmo_top
// Assumes: Wake and sleep counts are fixed, so the run is long
// Notes  : Slot changes are made with the link stopped
`timescale 1ns/1ns
module tb;
  import pdmo_pkg::*;
  logic mclk, rstn, lr_select, mod_valid, mod_bit, feed, run;
  logic mod_ready, data_out, data_oe_n, asleep, link_clk;
  logic left_bit, right_bit, left_drv, right_drv;
  int   fails = 0, checked = 0, i, n;
  // Rows: select, fed bit | left driven, right driven, slot bit; select only goes low to high
  logic [4:0] rows [4] = '{5'h02, 5'h0b, 5'h14, 5'h1d};

  pdmo_top pdmo_top_i (.mclk(mclk), .rstn(rstn), .link_clk(link_clk), .lr_select(lr_select),
    .mod_valid(mod_valid), .mod_ready(mod_ready), .mod_bit(mod_bit), .data_out(data_out),
    .data_oe_n(data_oe_n), .asleep(asleep));
  pdmo_host_model pdmo_host_model_i (.run(run), .data_out(data_out), .data_oe_n(data_oe_n),
    .link_clk(link_clk), .left_bit(left_bit), .right_bit(right_bit), .left_drv(left_drv),
    .right_drv(right_drv));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Source honours mod_ready
  always @(negedge mclk) mod_valid <= feed && mod_ready;

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic links(input int k);
    repeat (k * 8) @(negedge mclk);
  endtask

  initial begin
    #6ms;
    fails++;
    results;
  end

  initial begin
    {rstn, lr_select, mod_bit, feed, run} = 5'h00;
    repeat (8) @(negedge mclk);
    check({data_oe_n, asleep, mod_ready}, 4'h6);
    {rstn, feed, run} = 3'b111;
    // no drive inside the wake interval
    links(32700);
    check(data_oe_n, 4'h1);
    links(80);
    for (i = 0; i < 4; i++) begin
      run = 1'b0;
      links(1);
      {lr_select, mod_bit} = rows[i][4:3];
      run = 1'b1;
      links(10);
      check({left_drv, right_drv, lr_select ? left_bit : right_bit}, rows[i][2:0]);
    end
    // Link stalled: buffer fills and refuses
    run = 1'b0;
    n = 0;
    while (mod_ready === 1'b1 && n < 20) begin
      n++;
      @(negedge mclk);
    end
    check(mod_ready, 4'h0);
    // Drain to empty; an empty buffer repeats the last bit
    {feed, mod_bit, run} = 3'b001;
    links(10);
    check({mod_ready, left_drv, left_bit}, 4'h7);
    // Link held still past the sleep limit
    run = 1'b0;
    repeat (SLEEP_CYCLES + 50) @(negedge mclk);
    check({asleep, data_oe_n}, 4'h3);
    // Clock back: awake again, but the line stays released while counting
    run = 1'b1;
    links(10);
    check({asleep, data_oe_n}, 4'h1);
    // Reset while still counting the wake interval, link still toggling
    rstn = 1'b0;
    @(negedge mclk);
    check({data_oe_n, asleep, mod_ready}, 4'h6);
    rstn = 1'b1;
    links(2);
    check({asleep, mod_ready, data_oe_n}, 4'h3);
    results;
  end
endmodule
